// *** design/mhbs_pkg.sv ***
// shared constants and types of the motor holding brake sequencer
`default_nettype none

package mhbs_pkg;

    // ==========================================================
    // clock and timer resolution
    localparam int CLK_HZ   = 10_000_000;
    localparam int TICK_MS  = 10;                      // timer step
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS; // cycles per step
    localparam int TW       = 15;                      // timer setting width
    localparam int FW       = 10;                      // frequency width, Hz

    // ==========================================================
    // times in ms as printed, and in timer steps
    localparam int MAG_RST_MS   = 1000;
    localparam int MAG_MAX_MS   = 20000;
    localparam int OPEN_RST_MS  = 100;
    localparam int OPEN_MAX_MS  = 20000;
    localparam int HOLD_RST_MS  = 100;
    localparam int HOLD_MAX_MS  = 20000;
    localparam int WATCH_RST_MS = 4000;
    localparam int WATCH_MAX_MS = 300000;
    localparam int MAG_RST      = MAG_RST_MS / TICK_MS;
    localparam int MAG_MAX      = MAG_MAX_MS / TICK_MS;
    localparam int OPEN_RST     = OPEN_RST_MS / TICK_MS;
    localparam int OPEN_MAX     = OPEN_MAX_MS / TICK_MS;
    localparam int HOLD_RST     = HOLD_RST_MS / TICK_MS;
    localparam int HOLD_MAX     = HOLD_MAX_MS / TICK_MS;
    localparam int WATCH_RST    = WATCH_RST_MS / TICK_MS;
    localparam int WATCH_MAX    = WATCH_MAX_MS / TICK_MS;
    localparam int FREQ_RST_HZ  = 0;
    localparam int FREQ_MAX_HZ  = 650;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] A_ACCESS = 8'h00;
    localparam logic [7:0] A_MODE   = 8'h04;
    localparam logic [7:0] A_MAG    = 8'h08;
    localparam logic [7:0] A_OPEN   = 8'h0C;
    localparam logic [7:0] A_HOLD   = 8'h10;
    localparam logic [7:0] A_WATCH  = 8'h14;
    localparam logic [7:0] A_FREQ   = 8'h18;
    localparam logic [7:0] A_FORCE  = 8'h1C;
    localparam logic [7:0] A_STATUS = 8'h20;
    localparam logic [7:0] A_ISTAT  = 8'h24;
    localparam logic [7:0] A_IMASK  = 8'h28;

    // ==========================================================
    // field encodings and positions
    localparam logic [1:0] MODE_LOCKED = 2'h0;
    localparam logic [1:0] MODE_ON     = 2'h1;
    localparam logic [1:0] MODE_BOOST  = 2'h2;
    localparam logic [1:0] LVL_RST     = 2'h1;
    localparam logic [1:0] LVL_EXT     = 2'h2;
    localparam logic [1:0] LVL_EXPERT  = 2'h3;
    localparam int SB_ENGAGED = 0;
    localparam int SB_RELEASE = 1;
    localparam int SB_PULSE   = 2;
    localparam int SB_STATE   = 4;
    localparam int IW          = 4;
    localparam int IRQ_OPENED  = 0;
    localparam int IRQ_CLOSED  = 1;
    localparam int IRQ_TIMEOUT = 2;
    localparam int IRQ_COAST   = 3;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_MAGN, ST_OPEN, ST_RUN, ST_STOP, ST_HOLD
    } mhbs_state_t;

endpackage

`default_nettype wire

// *** design/mhbs_tick.sv ***
// timer step pulse generator
`default_nettype none

module mhbs_tick #(
    parameter int unsigned CYC = 100
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // step pulse
    output logic      tick
);
    localparam int CW = $clog2(CYC + 1);
    logic [CW-1:0] cnt_q;

    // free running divider
    always_ff @(posedge clk) begin
        if (rst || cnt_q == CW'(CYC - 1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign tick = (cnt_q == CW'(CYC - 1));
endmodule

`default_nettype wire

// *** design/mhbs_timer.sv ***
// loadable down counter stepped by the timer pulse
`default_nettype none

module mhbs_timer
    import mhbs_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // control
    input  wire logic          tick,
    input  wire logic          load,
    input  wire logic [TW-1:0] value,
    // status
    output logic               done
);
    logic [TW-1:0] cnt_q;

    // load on state entry with one spare step, so a setting never ends early
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= value + 1'b1;
        end else if (tick && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // no load term: load is decoded from done and must not feed back
    assign done = (cnt_q == '0);
endmodule

`default_nettype wire

// *** design/mhbs_top.sv ***
// motor holding brake sequencer with apb registers
//
// Operation
// - coast stop closes the brake at once, ignoring closing time and speed
// - enable selector: 0 locked (reset), 1 enabled, 2 enabled with boost
// - magnetizing time 0..20 s, reset 1 s, nonzero while brake used
// - minimum frequency 0..650 Hz, reset 0, floors the commanded frequency
// - opening delay 0..20 s, reset 0.1 s, wait before release
// - runout hold 0..20 s, reset 0.1 s, hold after brake close
// - zero-speed watch time 0..300 s, reset 4 s
// - force release 1 clears engaged flag and opens brake, even unpowered
// - force release writable only at access level 3
// - brake settings writable only at access level 2 or more
//
// Our own choices: the APB register port and the register offsets.
`default_nettype none

module mhbs_top
    import mhbs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // drive commands from pins
    input  wire logic          run_command,
    input  wire logic          ramp_stop_command,
    input  wire logic          fast_stop_command,
    input  wire logic          coast_stop_command,
    // speed path, same clock
    input  wire logic          zero_speed,
    input  wire logic [FW-1:0] freq_setpoint,
    // drive outputs
    output logic               brake_release_out,
    output logic               brake_boost_out,
    output logic               brake_engaged_flag,
    output logic               pulse_enable,
    output logic               ramp_enable,
    output logic [FW-1:0]      freq_command,
    output logic               irq
);

    // ==========================================================
    // decoding helpers

    // address holds a register
    function automatic logic reg_hit(input logic [7:0] a);
        return a inside {A_ACCESS, A_MODE, A_MAG, A_OPEN, A_HOLD, A_WATCH,
                         A_FREQ, A_FORCE, A_STATUS, A_ISTAT, A_IMASK};
    endfunction

    // write accepted for this level and value
    function automatic logic wr_ok(input logic [7:0] a, input logic [31:0] d,
                                   input logic [1:0] lvl, input logic [1:0] md,
                                   input logic [TW-1:0] mag);
        logic ext;
        ext = (lvl >= LVL_EXT);
        unique case (a)
            A_ACCESS: wr_ok = (d <= 32'(LVL_EXPERT));
            A_MODE:   wr_ok = ext && d <= 32'(MODE_BOOST)
                              && (d[1:0] == MODE_LOCKED || mag != '0);
            A_MAG:    wr_ok = ext && d <= 32'(MAG_MAX)
                              && (d != '0 || md == MODE_LOCKED);
            A_OPEN:   wr_ok = ext && d <= 32'(OPEN_MAX);
            A_HOLD:   wr_ok = ext && d <= 32'(HOLD_MAX);
            A_WATCH:  wr_ok = ext && d <= 32'(WATCH_MAX);
            A_FREQ:   wr_ok = ext && d <= 32'(FREQ_MAX_HZ);
            A_FORCE:  wr_ok = (lvl == LVL_EXPERT) && d <= 32'h1;
            A_IMASK:  wr_ok = 1'b1;
            default:  wr_ok = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // signals

    logic [3:0]    pin_s1_q;
    logic [3:0]    pin_s2_q;
    logic          run_s, ramp_s, fast_s, coast_s;
    logic [1:0]    lvl_q;
    logic [1:0]    mode_q;
    logic [TW-1:0] mag_q, open_q, hold_q, watch_q;
    logic [FW-1:0] floor_q;
    logic          force_q;
    logic [IW-1:0] istat_q, imask_q, ev;
    logic [31:0]   prdata_q, rdata;
    logic          acc, wr_en, ok, rd_clr;
    mhbs_state_t   state_q, state_d;
    logic          go, t_load, t_done, tick, rel_d;
    logic [TW-1:0] t_val;
    logic          rel_q, boost_q, eng_q, pulse_q, ramp_q;
    logic [FW-1:0] freq_q;

    // ==========================================================
    // pin synchronisers

    // two flops on every command pin
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {coast_stop_command, fast_stop_command,
                         ramp_stop_command, run_command};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign {coast_s, fast_s, ramp_s, run_s} = pin_s2_q;

    // ==========================================================
    // apb slave

    // zero wait state, error on unmapped or refused access
    assign acc     = psel && penable;
    assign ok      = wr_ok(paddr, pwdata, lvl_q, mode_q, mag_q);
    assign wr_en   = acc && pwrite && ok;
    assign rd_clr  = acc && !pwrite && paddr == A_ISTAT;
    assign pready  = 1'b1;
    assign pslverr = acc && (!reg_hit(paddr) || (pwrite && !ok));
    assign prdata  = prdata_q;

    // read mux
    always_comb begin
        rdata = '0;
        case (paddr)
            A_ACCESS: rdata[1:0]    = lvl_q;
            A_MODE:   rdata[1:0]    = mode_q;
            A_MAG:    rdata[TW-1:0] = mag_q;
            A_OPEN:   rdata[TW-1:0] = open_q;
            A_HOLD:   rdata[TW-1:0] = hold_q;
            A_WATCH:  rdata[TW-1:0] = watch_q;
            A_FREQ:   rdata[FW-1:0] = floor_q;
            A_FORCE:  rdata[0]      = force_q;
            A_STATUS: begin
                rdata[SB_ENGAGED]    = eng_q;
                rdata[SB_RELEASE]    = rel_q;
                rdata[SB_PULSE]      = pulse_q;
                rdata[SB_STATE +: 3] = state_q;
            end
            A_ISTAT:  rdata[IW-1:0] = istat_q;
            A_IMASK:  rdata[IW-1:0] = imask_q;
            default:  rdata = '0;
        endcase
    end

    // read data captured in the setup cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_q <= '0;
        end else if (psel && !penable) begin
            prdata_q <= rdata;
        end
    end

    // ==========================================================
    // settings registers

    // writes pass only at the needed access level
    always_ff @(posedge clk) begin
        if (rst) begin
            lvl_q   <= LVL_RST;
            mode_q  <= MODE_LOCKED;
            mag_q   <= TW'(MAG_RST);
            open_q  <= TW'(OPEN_RST);
            hold_q  <= TW'(HOLD_RST);
            watch_q <= TW'(WATCH_RST);
            floor_q <= FW'(FREQ_RST_HZ);
            force_q <= 1'b0;
            imask_q <= '0;
        end else if (wr_en) begin
            case (paddr)
                A_ACCESS: lvl_q   <= pwdata[1:0];
                A_MODE:   mode_q  <= pwdata[1:0];
                A_MAG:    mag_q   <= pwdata[TW-1:0];
                A_OPEN:   open_q  <= pwdata[TW-1:0];
                A_HOLD:   hold_q  <= pwdata[TW-1:0];
                A_WATCH:  watch_q <= pwdata[TW-1:0];
                A_FREQ:   floor_q <= pwdata[FW-1:0];
                A_FORCE:  force_q <= pwdata[0];
                A_IMASK:  imask_q <= pwdata[IW-1:0];
                default:  ;
            endcase
        end
    end

    // ==========================================================
    // interrupts

    // sticky events, read clears only bits that were returned
    always_ff @(posedge clk) begin
        if (rst) begin
            istat_q <= '0;
        end else begin
            istat_q <= (istat_q & ~(rd_clr ? prdata_q[IW-1:0] : '0)) | ev;
        end
    end

    assign irq = |(istat_q & imask_q);

    // ==========================================================
    // sequencer

    mhbs_tick #(
        .CYC   (TICK_CYCLES)
    ) u_tick (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick)
    );

    mhbs_timer u_timer (
        .clk   (clk),
        .rst   (rst),
        .tick  (tick),
        .load  (t_load),
        .value (t_val),
        .done  (t_done)
    );

    assign go = run_s && !ramp_s && !fast_s && !coast_s;

    // next state and events
    always_comb begin
        state_d = state_q;
        ev      = '0;
        unique case (state_q)
            ST_IDLE: if (go) state_d = ST_MAGN;
            ST_MAGN: begin
                if (!go) begin
                    state_d = ST_IDLE;
                end else if (t_done) begin
                    state_d = (mode_q == MODE_LOCKED) ? ST_RUN : ST_OPEN;
                end
            end
            ST_OPEN: begin
                if (!go) begin
                    state_d = ST_IDLE;
                end else if (t_done) begin
                    state_d         = ST_RUN;
                    ev[IRQ_OPENED]  = 1'b1;
                end
            end
            ST_RUN: if (!go) state_d = ST_STOP;
            ST_STOP: begin
                if (zero_speed || t_done) begin
                    state_d          = (mode_q == MODE_LOCKED) ? ST_IDLE : ST_HOLD;
                    ev[IRQ_CLOSED]   = (mode_q != MODE_LOCKED);
                    ev[IRQ_TIMEOUT]  = !zero_speed;
                end
            end
            ST_HOLD: if (t_done) state_d = ST_IDLE;
        endcase
        if (coast_s && state_q != ST_IDLE) begin
            state_d        = ST_IDLE;
            ev[IRQ_COAST]  = 1'b1;
        end
    end

    // timer load value for the state being entered
    always_comb begin
        t_load = (state_d != state_q);
        unique case (state_d)
            ST_MAGN: t_val = mag_q;
            ST_OPEN: t_val = open_q;
            ST_STOP: t_val = watch_q;
            ST_HOLD: t_val = hold_q;
            default: t_val = '0;
        endcase
    end

    // brake released in run and ramp down unless mode is locked, or when forced
    assign rel_d = ((mode_q != MODE_LOCKED)
                    && (state_d == ST_RUN || state_d == ST_STOP))
                   || force_q;

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // registered drive outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            rel_q   <= 1'b0;
            boost_q <= 1'b0;
            eng_q   <= 1'b1;
            pulse_q <= 1'b0;
            ramp_q  <= 1'b0;
            freq_q  <= '0;
        end else begin
            rel_q   <= rel_d;
            boost_q <= rel_d && mode_q == MODE_BOOST;
            eng_q   <= !rel_d;
            pulse_q <= (state_d != ST_IDLE);
            ramp_q  <= (state_d == ST_RUN);
            freq_q  <= (state_d != ST_RUN) ? '0 :
                       (freq_setpoint < floor_q) ? floor_q : freq_setpoint;
        end
    end

    assign brake_release_out  = rel_q;
    assign brake_boost_out    = boost_q;
    assign brake_engaged_flag = eng_q;
    assign pulse_enable       = pulse_q;
    assign ramp_enable        = ramp_q;
    assign freq_command       = freq_q;

    // ==========================================================
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_coast_close: assert property (
        coast_s && !force_q |=> !brake_release_out && !pulse_enable)
        else $error("coast stop left brake released");
    chk_locked_mode: assert property (
        mode_q == MODE_LOCKED && !force_q |=> !brake_release_out)
        else $error("locked brake mode released brake");
    chk_boost_mode: assert property (
        brake_boost_out |-> brake_release_out && $past(mode_q) == MODE_BOOST)
        else $error("boost without boost mode");
    chk_mag_nonzero: assert property (
        mode_q != MODE_LOCKED |-> mag_q != '0 && mag_q <= TW'(MAG_MAX))
        else $error("magnetizing time zero with brake in use");
    chk_freq_floor: assert property (
        ramp_enable |-> freq_command >= $past(floor_q))
        else $error("frequency below floor");
    chk_time_limits: assert property (
        open_q <= TW'(OPEN_MAX) && hold_q <= TW'(HOLD_MAX)
        && watch_q <= TW'(WATCH_MAX))
        else $error("time setting out of range");
    chk_force_open: assert property (
        force_q |=> brake_release_out && !brake_engaged_flag)
        else $error("forced release not applied");
    chk_force_level: assert property (
        $changed(force_q) |-> $past(lvl_q) == LVL_EXPERT)
        else $error("force release changed below expert level");
    chk_cfg_level: assert property (
        $changed(mag_q) || $changed(mode_q) || $changed(open_q)
        |-> $past(lvl_q) >= LVL_EXT)
        else $error("brake setting changed below extended level");
    chk_release_order: assert property (
        state_q == ST_OPEN && state_d == ST_RUN |-> t_done ##1 ramp_enable)
        else $error("release before opening delay");
    chk_hold_closed: assert property (
        state_q == ST_HOLD && !force_q |-> !brake_release_out && pulse_enable)
        else $error("hold phase with brake open or pulses off");

    cov_full_cycle: cover property (state_q == ST_HOLD ##1 state_q == ST_IDLE);
    cov_coast_run:  cover property (state_q == ST_RUN && coast_s);
    cov_forced:     cover property (force_q && !pulse_enable);
    cov_timeout:    cover property (ev[IRQ_TIMEOUT]);

endmodule

`default_nettype wire

// *** verif/mhbs_brake_model.sv ***
// brake relay and motor model at the far side of the sequencer
`default_nettype none

module mhbs_brake_model #(
    parameter int OPEN_CYC  = 10,
    parameter int CLOSE_CYC = 5,
    parameter int SPIN_CYC  = 20
) (
    // clock and drive side
    input  wire logic clk,
    input  wire logic release_cmd,
    input  wire logic ramp,
    input  wire logic stall,
    // motor side
    output logic      zero_speed,
    output var logic  brake_open
);
    timeunit 1ns;
    timeprecision 1ns;
    int rel_cnt  = 0;
    int spin_cnt = 0;
    initial brake_open = 1'b0;

    // ==========================================================
    // armature follows the relay after its release or closing time,
    // both shorter than the delays the bench programs
    always @(posedge clk) begin
        if (release_cmd != brake_open) rel_cnt <= rel_cnt + 1;
        else rel_cnt <= 0;
        if (release_cmd && !brake_open && rel_cnt >= OPEN_CYC - 1) brake_open <= 1'b1;
        if (!release_cmd && brake_open && rel_cnt >= CLOSE_CYC - 1) brake_open <= 1'b0;
    end

    // motor turns while ramping, runs down after; stall keeps it turning
    always @(posedge clk) begin
        if (ramp) spin_cnt <= SPIN_CYC;
        else if (spin_cnt > 0 && !stall) spin_cnt <= spin_cnt - 1;
    end
    assign zero_speed = (spin_cnt == 0);
endmodule

`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench of the motor holding brake sequencer
`default_nettype none

module testbench;
    import mhbs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 10;
    logic          clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rv;
    logic          run_c, ramp_c, fast_c, coast_c, stall, zs, bopen, ev;
    logic          rel, boost, eng, pen, ren, irq;
    logic [FW-1:0] fset, fcmd;
    int            miscompares = 0;
    int            checked = 0;
    int            cyc = 0;
    int            n;

    // ==========================================================
    // clock, timeout and parts
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    mhbs_top #(.TICK_CYCLES(TK)) u_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .run_command(run_c), .ramp_stop_command(ramp_c),
        .fast_stop_command(fast_c), .coast_stop_command(coast_c), .zero_speed(zs),
        .freq_setpoint(fset), .brake_release_out(rel), .brake_boost_out(boost),
        .brake_engaged_flag(eng), .pulse_enable(pen), .ramp_enable(ren),
        .freq_command(fcmd), .irq(irq));
    mhbs_brake_model u_brake (.clk(clk), .release_cmd(rel), .ramp(ren), .stall(stall),
        .zero_speed(zs), .brake_open(bopen));

    // ==========================================================
    // tasks
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // one apb transfer, answer taken at the edge that sees pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rv = prdata;
        ev = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        cmp({31'h0, ev}, {31'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp(rv, exp);
    endtask
    // cycles until release (sel 0) or pulses (sel 1) reach v
    task automatic wait_lvl(input int sel, input logic v);
        n = 0;
        while (((sel == 0) ? rel : pen) !== v && n < 5000) begin
            @(posedge clk);
            n++;
        end
        cmp(32'(n < 5000), 32'h1);
    endtask
    task automatic run_up;
        @(posedge clk);
        run_c <= 1'b1;
        wait_lvl(0, 1'b1);
        cmp(32'(n >= 5 * TK && n <= 7 * TK + 8), 32'h1);
        cmp({31'h0, ren}, 32'h1);
        cmp({22'h0, fcmd}, 32'h32);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, run_c, ramp_c, fast_c, coast_c, stall} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        fset = 10'h014;
        rst = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // reset values and refusals
        rd(A_ACCESS, 32'h1);
        rd(A_MODE, 32'h0);
        rd(A_MAG, 32'(MAG_RST));
        rd(A_OPEN, 32'(OPEN_RST));
        rd(A_HOLD, 32'(HOLD_RST));
        rd(A_WATCH, 32'(WATCH_RST));
        rd(A_FREQ, 32'h0);
        rd(A_IMASK, 32'h0);
        cmp({31'h0, eng}, 32'h1);
        wr(A_MODE, 32'h1, 1'b1);
        wr(8'h30, 32'h0, 1'b1);
        wr(A_STATUS, 32'h0, 1'b1);
        wr(A_ACCESS, 32'h2, 1'b0);
        wr(A_FORCE, 32'h1, 1'b1);
        wr(A_MODE, 32'h3, 1'b1);
        wr(A_MAG, 32'(MAG_MAX + 1), 1'b1);
        wr(A_OPEN, 32'(OPEN_MAX + 1), 1'b1);
        wr(A_HOLD, 32'(HOLD_MAX + 1), 1'b1);
        wr(A_WATCH, 32'(WATCH_MAX + 1), 1'b1);
        wr(A_FREQ, 32'(FREQ_MAX_HZ + 1), 1'b1);
        wr(A_WATCH, 32'(WATCH_MAX), 1'b0);
        wr(A_FREQ, 32'(FREQ_MAX_HZ), 1'b0);
        wr(A_MAG, 32'h2, 1'b0);
        wr(A_OPEN, 32'h3, 1'b0);
        wr(A_HOLD, 32'h2, 1'b0);
        wr(A_WATCH, 32'h1E, 1'b0);
        wr(A_FREQ, 32'h32, 1'b0);
        // mode 1 ends by ramp stop, mode 2 by coast stop
        for (int m = 1; m <= 2; m++) begin
            wr(A_MODE, 32'(m), 1'b0);
            wr(A_MAG, 32'h0, 1'b1);
            run_up();
            cmp({31'h0, boost}, 32'(m == 2));
            repeat (12) @(posedge clk);
            cmp({31'h0, bopen}, 32'h1);
            if (m == 1) begin
                cmp({31'h0, irq}, 32'h0);
                wr(A_IMASK, 32'hF, 1'b0);
                @(posedge clk);
                cmp({31'h0, irq}, 32'h1);
                ramp_c <= 1'b1;
                wait_lvl(0, 1'b0);
                cmp(32'(n < 30 * TK), 32'h1);
                cmp({31'h0, pen}, 32'h1);
                wait_lvl(1, 1'b0);
                cmp(32'(n >= 2 * TK - 2 && n <= 3 * TK + 3), 32'h1);
                apb(1'b0, A_ISTAT, 32'h0);
                cmp(rv & 32'h3, 32'h3);
                rd(A_ISTAT, 32'h0);
                cmp({31'h0, irq}, 32'h0);
                ramp_c <= 1'b0;
            end else begin
                coast_c <= 1'b1;
                repeat (4) @(posedge clk);
                cmp({29'h0, rel, pen, boost}, 32'h0);
                apb(1'b0, A_ISTAT, 32'h0);
                cmp({31'h0, rv[IRQ_COAST]}, 32'h1);
                coast_c <= 1'b0;
            end
            run_c <= 1'b0;
            repeat (6) @(posedge clk);
        end
        // fast stop with the motor never reaching zero speed
        wr(A_MODE, 32'h1, 1'b0);
        wr(A_WATCH, 32'h3, 1'b0);
        run_up();
        stall <= 1'b1;
        fast_c <= 1'b1;
        wait_lvl(0, 1'b0);
        cmp(32'(n >= 3 * TK && n <= 4 * TK + 8), 32'h1);
        wait_lvl(1, 1'b0);
        apb(1'b0, A_ISTAT, 32'h0);
        cmp({31'h0, rv[IRQ_TIMEOUT]}, 32'h1);
        {stall, fast_c, run_c} <= 3'h0;
        // locked mode: motor runs above the floor, brake stays closed
        wr(A_MODE, 32'h0, 1'b0);
        fset <= 10'h064;
        run_c <= 1'b1;
        repeat (45) @(posedge clk);
        cmp({30'h0, rel, ren}, 32'h1);
        cmp({22'h0, fcmd}, 32'h64);
        run_c <= 1'b0;
        repeat (30) @(posedge clk);
        cmp({30'h0, rel, pen}, 32'h0);
        // forced release while powered down
        wr(A_ACCESS, 32'h3, 1'b0);
        wr(A_FORCE, 32'h1, 1'b0);
        repeat (2) @(posedge clk);
        cmp({29'h0, rel, eng, pen}, 32'h4);
        wr(A_FORCE, 32'h0, 1'b0);
        repeat (2) @(posedge clk);
        cmp({30'h0, rel, eng}, 32'h1);
        finish_test();
    end
endmodule

`default_nettype wire
